// ---- ladder_coil_logic.sv ----
// Purpose: cyclic ladder scan with contact evaluation and coil functions
// Assumes: program loaded through prog_wr_in while stopped
// Notes:   one rung per two cycles (fetch, evaluate)
//
// Behaviour
// - in run, scan whole program repeatedly; idle while stopped
// - each rung flows from leftmost contact toward its coil
// - store holds 256 rungs of four contacts and one coil
// - leftmost contact field is always fed with logic true
// - open contact gives operand, closed contact gives its inverse
// - coils update in run from power flow and coil function
// - contactor coil copies power flow of the current scan
// - impulse coil toggles relay on each rising input
// - set coil drives 1, held until a reset coil gets power
// - set and reset in one scan: later evaluated rung wins
// - repeated non-retentive coils: last evaluated rung decides
// - set, reset, impulse on many rungs share one relay state
// - stop clears coils except retentive ones holding 1; reset clears all coils
// - negated contactor drives inverse of power flow
// - rising-edge coil pulses 1 for one scan on 0 to 1
// - falling-edge coil pulses 1 for one scan on 1 to 0
`timescale 1ns/1ps
module ladder_coil_logic
  import ladder_pkg::*;
#(
  parameter int RUNGS  = ladder_pkg::RUNG_COUNT,
  parameter int RELAYS = ladder_pkg::RELAY_COUNT
) (
  input  wire logic                               clk_sys_in,
  input  wire logic                               reset_n_in,
  input  wire logic                               run_in,
  input  wire ladder_pkg::prog_wr_t               prog_wr_in,
  input  wire logic [ladder_pkg::INPUT_COUNT-1:0] inputs_in,
  input  wire logic [ladder_pkg::RELAY_COUNT-1:0] retentive_in,
  output logic      [ladder_pkg::RELAY_COUNT-1:0] relays_out,
  output logic                                    scan_done_out,
  output logic                                    running_out
);
  import ladder_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_EVAL  = 3'b100
  } state_t;

  state_t                   state_r, state_nxt;
  logic [RUNG_AW-1:0]       rung_r;
  logic [RELAY_COUNT-1:0]   relay_r;
  logic [RUNG_COUNT-1:0]    prev_in_r;   // coil input seen last scan, per rung
  logic [INPUT_COUNT-1:0]   in_s1_r, in_s2_r, in_s3_r, in_stable_r;
  logic [2:0]               run_sync_r;
  logic                     run_stable_r;
  logic [RUNG_W-1:0]        rung_word;
  rung_t                    rung;

  // inputs from pins: 3 stages, accept when stages 2 and 3 agree
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      in_s1_r      <= '0;
      in_s2_r      <= '0;
      in_s3_r      <= '0;
      in_stable_r  <= '0;
      run_sync_r   <= '0;
      run_stable_r <= 1'b0;
    end else begin
      in_s1_r     <= inputs_in;
      in_s2_r     <= in_s1_r;
      in_s3_r     <= in_s2_r;
      // hold the old level while stages 2 and 3 disagree, follow them once they agree
      in_stable_r <= (in_stable_r & (in_s2_r ^ in_s3_r)) | (in_s2_r & in_s3_r);
      run_sync_r  <= {run_sync_r[1:0], run_in};
      if (run_sync_r[1] == run_sync_r[2]) begin
        run_stable_r <= run_sync_r[2];
      end
    end
  end

  rung_store #(
    .DEPTH (RUNG_COUNT),
    .AW    (RUNG_AW),
    .W     (RUNG_W)
  ) u_store (
    .clk_sys_in  (clk_sys_in),
    .wr_en_in    (prog_wr_in.we && (state_r == ST_IDLE)),
    .wr_addr_in  (prog_wr_in.addr),
    .wr_data_in  (prog_wr_in.data),
    .rd_addr_in  (rung_r),
    .rd_data_out (rung_word)
  );

  assign rung = rung_t'(rung_word);

  // contact evaluation, left to right, rail is true at the left end
  logic [CONTACT_COUNT:0] flow;
  logic [CONTACT_COUNT-1:0] contact_val;
  assign flow[0] = 1'b1;
  genvar g;
  generate
    for (g = 0; g < CONTACT_COUNT; g++) begin : g_contact
      wire contact_t c       = rung.contacts[CONTACT_COUNT-1-g];
      wire logic     operand = (c.src == SRC_INPUT) ? in_stable_r[c.idx] : relay_r[c.idx];
      // empty field treated as a wire so partial rungs still conduct
      assign contact_val[g] = (c.src == SRC_EMPTY) ? 1'b1 : (operand ^ c.closed_n);
      assign flow[g+1]      = flow[g] & contact_val[g];
    end
  endgenerate

  wire logic power    = flow[CONTACT_COUNT];
  wire logic prev_in  = prev_in_r[rung_r];
  wire logic cur_q    = relay_r[rung.coil_idx];
  wire logic rise     = power & ~prev_in;
  wire logic fall     = ~power & prev_in;
  wire logic last_rng = (rung_r == RUNG_AW'(RUNGS - 1));

  // coil function; only this rung's relay changes
  logic coil_q;
  always_comb begin
    coil_q = cur_q;
    unique case (rung.fn)
      COIL_NONE:    coil_q = cur_q;
      COIL_CONTACT: coil_q = power;
      COIL_NEGATE:  coil_q = ~power;
      COIL_IMPULSE: coil_q = cur_q ^ rise;
      COIL_SET:     coil_q = cur_q | power;
      COIL_RESET:   coil_q = cur_q & ~power;
      COIL_RISE:    coil_q = rise;
      COIL_FALL:    coil_q = fall;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:  state_nxt = run_stable_r ? ST_FETCH : ST_IDLE;
      ST_FETCH: state_nxt = !run_stable_r ? ST_IDLE : ST_EVAL;
      ST_EVAL:  state_nxt = !run_stable_r ? ST_IDLE : ST_FETCH;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r       <= ST_IDLE;
      rung_r        <= '0;
      relay_r       <= '0;
      prev_in_r     <= '0;
      scan_done_out <= 1'b0;
      running_out   <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      running_out   <= (state_nxt != ST_IDLE);
      scan_done_out <= 1'b0;
      if (state_r == ST_EVAL) begin
        // sequential write: later rungs read it and later coils override
        relay_r[rung.coil_idx] <= coil_q;
        prev_in_r[rung_r]      <= power;
        rung_r                 <= last_rng ? '0 : rung_r + 1'b1;
        scan_done_out          <= last_rng;
        if (!run_stable_r) begin
          relay_r   <= relay_r & retentive_in;
          prev_in_r <= '0;
          rung_r    <= '0;
        end
      end else if (state_r == ST_FETCH && !run_stable_r) begin
        relay_r   <= relay_r & retentive_in;
        prev_in_r <= '0;
        rung_r    <= '0;
      end
    end
  end

  assign relays_out = relay_r;

  // assertions
  chk_stop_clears: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r != ST_IDLE) && !run_stable_r |=> ((relay_r & ~$past(retentive_in)) == '0))
    else $error("non-retentive relay survived stop");
  chk_idle_frozen: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r == ST_IDLE) && $past(state_r == ST_IDLE) |-> $stable(relay_r))
    else $error("relay changed while stopped");
  chk_contactor: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r == ST_EVAL) && run_stable_r && rung.fn == COIL_CONTACT |=> relay_r[$past(rung.coil_idx)] == $past(power))
    else $error("contactor coil wrong");
  chk_negate: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r == ST_EVAL) && run_stable_r && rung.fn == COIL_NEGATE |=> relay_r[$past(rung.coil_idx)] == !$past(power))
    else $error("negated coil wrong");
  chk_set_holds: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r == ST_EVAL) && run_stable_r && rung.fn == COIL_SET && power |=> relay_r[$past(rung.coil_idx)])
    else $error("set coil did not set");
  chk_reset_clr: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r == ST_EVAL) && run_stable_r && rung.fn == COIL_RESET && power |=> !relay_r[$past(rung.coil_idx)])
    else $error("reset coil did not clear");
  chk_impulse_tog: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r == ST_EVAL) && run_stable_r && rung.fn == COIL_IMPULSE && rise |=> relay_r[$past(rung.coil_idx)] != $past(cur_q))
    else $error("impulse coil did not toggle");
  chk_edge_pulse: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r == ST_EVAL) && run_stable_r && rung.fn == COIL_RISE |=> relay_r[$past(rung.coil_idx)] == $past(power && !prev_in))
    else $error("rising pulse wrong");
  chk_fall_pulse: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r == ST_EVAL) && run_stable_r && rung.fn == COIL_FALL |=> relay_r[$past(rung.coil_idx)] == $past(!power && prev_in))
    else $error("falling pulse wrong");
  chk_rung_order: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r == ST_EVAL) && run_stable_r && !last_rng |=> rung_r == $past(rung_r) + 1'b1)
    else $error("rung order broken");
  // all contacts passing must leave power at the coil, which needs a live rail
  chk_rail_true: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r == ST_EVAL) && (contact_val == '1) |-> power)
    else $error("left rail not true");

  cov_scan_done: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in) scan_done_out);
  cov_stop_run:  cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r == ST_EVAL) && !run_stable_r);
  cov_impulse:   cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r == ST_EVAL) && rung.fn == COIL_IMPULSE && rise);
endmodule : ladder_coil_logic

// ---- ladder_coil_logic_bench.sv ----
// Purpose: self-checking bench for the ladder scan and its coil functions
// Assumes: rungs 0..3 stay empty so a stop lands before any coil is touched
// Notes:   a scan model in the bench predicts the relay image after each scan
`timescale 1ns/1ps
module ladder_coil_logic_bench;
  import ladder_pkg::*;
  logic                   clk_sys_in, reset_n_in, run_in, scan_done_out, running_out, run_seen;
  prog_wr_t               prog_wr_in;
  logic [INPUT_COUNT-1:0] inputs_in;
  logic [RELAY_COUNT-1:0] retentive_in, relays_out, mrel, q_exp[$];
  rung_t                  prog [RUNG_COUNT];
  logic                   mprev [RUNG_COUNT];
  int                     err_total, n_checks, stop_wait;

  ladder_coil_logic u_ladder_coil_logic (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .run_in(run_in),
    .prog_wr_in(prog_wr_in), .inputs_in(inputs_in), .retentive_in(retentive_in), .relays_out(relays_out),
    .scan_done_out(scan_done_out), .running_out(running_out));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task complete_run();
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task check();
    n_checks++;
    if (q_exp.size() == 0) begin
      err_total++;
      $display("BAD %0t result with nothing expected", $time);
    end else if (relays_out !== q_exp.pop_front()) begin
      err_total++;
      $display("BAD %0t relay image mismatch", $time);
    end
  endtask : check

  // stop image is read two cycles after running drops, to let the clear land
  always @(negedge clk_sys_in) begin
    if (scan_done_out === 1'b1) check();
    if (run_seen === 1'b1 && running_out === 1'b0) stop_wait = 2;
    else if (stop_wait > 0 && --stop_wait == 0) check();
    run_seen = running_out;
  end

  task wr(input int a, input rung_t d, input bit keep);
    @(posedge clk_sys_in) prog_wr_in <= '{we: 1'b1, addr: a[7:0], data: d};
    @(posedge clk_sys_in) prog_wr_in.we <= 1'b0;
    if (keep) prog[a] = d;
  endtask : wr

  function automatic rung_t mk(input int s, input bit nc, input coil_fn_t f, input int c);
    rung_t t;
    t = '0;
    t.contacts[3] = '{src: SRC_RELAY, closed_n: nc, idx: s[5:0]};
    t.fn = f;
    t.coil_idx = c[5:0];
    return t;
  endfunction : mk

  function automatic rung_t rnd_rung(input int r);
    rung_t t;
    for (int c = 0; c < CONTACT_COUNT; c++)
      t.contacts[c] = '{src: 2'($urandom % 3), closed_n: 1'($urandom), idx: 6'($urandom % 32)};
    t.fn = coil_fn_t'($urandom % 8);
    // non-retentive coils get a relay of their own per rung, retentive ones share 0..7
    if (t.fn inside {COIL_CONTACT, COIL_NEGATE, COIL_RISE, COIL_FALL}) t.coil_idx = 6'(8 + r);
    else t.coil_idx = 6'($urandom % 8);
    return t;
  endfunction : rnd_rung

  task automatic model_scan();
    logic pw, p;
    rung_t t;
    int k;
    for (int r = 0; r < RUNG_COUNT; r++) begin
      t = prog[r];
      k = t.coil_idx;
      p = mprev[r];
      pw = 1'b1;
      for (int c = CONTACT_COUNT - 1; c >= 0; c--)
        if (t.contacts[c].src != SRC_EMPTY) pw &= t.contacts[c].closed_n ^
          (t.contacts[c].src == SRC_INPUT ? inputs_in[t.contacts[c].idx] : mrel[t.contacts[c].idx]);
      case (t.fn)
        COIL_CONTACT: mrel[k] = pw;
        COIL_NEGATE:  mrel[k] = ~pw;
        COIL_IMPULSE: mrel[k] = mrel[k] ^ (pw & ~p);
        COIL_SET:     mrel[k] = mrel[k] | pw;
        COIL_RESET:   mrel[k] = mrel[k] & ~pw;
        COIL_RISE:    mrel[k] = pw & ~p;
        COIL_FALL:    mrel[k] = ~pw & p;
        default: ;
      endcase
      mprev[r] = (t.fn == COIL_NONE) ? p : pw;
    end
  endtask : model_scan

  task load(input bit rnd);
    for (int r = 0; r < RUNG_COUNT; r++) wr(r, (rnd && r >= 4 && r < 20) ? rnd_rung(r) : rung_t'('0), 1);
  endtask : load

  task run_round(input int scans);
    @(posedge clk_sys_in) inputs_in <= {$urandom, $urandom};
    retentive_in <= {$urandom, $urandom};
    repeat (4) @(posedge clk_sys_in);
    for (int s = 0; s < scans; s++) begin
      model_scan();
      q_exp.push_back(mrel);
    end
    run_in <= 1'b1;
    for (int i = 0; i < 100 && running_out !== 1'b1; i++) @(posedge clk_sys_in);
    n_checks++;
    if (running_out !== 1'b1) begin
      err_total++;
      $display("BAD %0t scan never started", $time);
    end
    wr(4 + $urandom % 16, rnd_rung(4), 0); // write while running must be ignored
    for (int i = 0; i < 8000 && q_exp.size() != 0; i++) @(posedge clk_sys_in);
    run_in <= 1'b0;
    mrel &= retentive_in;
    foreach (mprev[r]) mprev[r] = 1'b0;
    q_exp.push_back(mrel);
    for (int i = 0; i < 200 && (q_exp.size() != 0 || running_out !== 1'b0); i++) @(posedge clk_sys_in);
    repeat (40) @(posedge clk_sys_in);
    if (q_exp.size() != 0) begin
      err_total++;
      $display("BAD %0t expected results never appeared", $time);
      q_exp.delete();
    end
  endtask : run_round

  initial begin
    void'($urandom(66135));
    {err_total, n_checks, stop_wait, run_seen, run_in, mrel} = '0;
    reset_n_in = 1'b0;
    prog_wr_in = '0;
    inputs_in = '0;
    retentive_in = '0;
    foreach (mprev[r]) mprev[r] = 1'b0;
    repeat (2) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    load(0);
    wr(4, mk(0, 1, COIL_CONTACT, 0), 1);
    wr(5, mk(0, 0, COIL_IMPULSE, 1), 1);
    wr(6, mk(0, 0, COIL_RISE, 2), 1);
    wr(7, mk(0, 0, COIL_FALL, 3), 1);
    wr(8, mk(0, 0, COIL_NEGATE, 4), 1);
    wr(9, mk(0, 0, COIL_SET, 5), 1);
    wr(10, mk(1, 0, COIL_RESET, 5), 1);
    wr(11, mk(2, 0, COIL_IMPULSE, 1), 1);
    wr(12, mk(0, 1, COIL_CONTACT, 6), 1);
    wr(13, mk(0, 0, COIL_CONTACT, 6), 1);
    run_round(6);
    repeat (3) begin
      load(1);
      run_round(4);
    end
    complete_run();
  end

  initial begin
    #600000;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    complete_run();
  end
endmodule : ladder_coil_logic_bench

// ---- ladder_pkg.sv ----
// Purpose: shared constants and types for the ladder coil evaluator
// Assumes: 256 rungs, four contact fields and one coil field per rung
// Notes:   relay image is a flat bit array addressed by operand index
package ladder_pkg;

  localparam int RUNG_COUNT    = 256;
  localparam int RUNG_AW       = 8;
  localparam int CONTACT_COUNT = 4;
  localparam int RELAY_COUNT   = 64;
  localparam int RELAY_AW      = 6;
  localparam int INPUT_COUNT   = 64;

  // operand source of a contact field
  localparam logic [1:0] SRC_EMPTY = 2'h0;
  localparam logic [1:0] SRC_INPUT = 2'h1;
  localparam logic [1:0] SRC_RELAY = 2'h2;

  typedef enum logic [2:0] {
    COIL_NONE    = 3'h0,
    COIL_CONTACT = 3'h1,
    COIL_IMPULSE = 3'h2,
    COIL_SET     = 3'h3,
    COIL_RESET   = 3'h4,
    COIL_NEGATE  = 3'h5,
    COIL_RISE    = 3'h6,
    COIL_FALL    = 3'h7
  } coil_fn_t;

  typedef struct packed {
    logic [1:0]          src;
    logic                closed_n;  // normally-closed contact
    logic [RELAY_AW-1:0] idx;
  } contact_t;

  localparam int CONTACT_W = 2 + 1 + RELAY_AW;

  typedef struct packed {
    contact_t [CONTACT_COUNT-1:0] contacts;
    coil_fn_t                     fn;
    logic [RELAY_AW-1:0]          coil_idx;
  } rung_t;

  localparam int RUNG_W = CONTACT_COUNT * CONTACT_W + 3 + RELAY_AW;

  typedef struct packed {
    logic               we;
    logic [RUNG_AW-1:0] addr;
    rung_t              data;
  } prog_wr_t;

endpackage : ladder_pkg

// ---- rung_store.sv ----
// Purpose: program store holding one rung word per rung
// Assumes: written only while the evaluator is stopped
// Notes:   registered read, one cycle latency
`timescale 1ns/1ps
module rung_store #(
  parameter int DEPTH = 256,
  parameter int AW    = 8,
  parameter int W     = 33
) (
  input  wire logic          clk_sys_in,
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [W-1:0]  wr_data_in,
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [W-1:0]  rd_data_out
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule : rung_store
